// ---- rtl/ratc_regs.svh ----
// Purpose: constants of the resolver angle tracking counter
// Assumes: 250 MHz system clock
// Notes: definitions only
`ifndef RATC_REGS_SVH
`define RATC_REGS_SVH

// Channel layout: gimbals first, then optics shaft, then trunnion
`define RATC_NCH 5
`define RATC_NGIM 3
`define RATC_TRUN_CH 4

// Counter widths
`define RATC_ANG_W 16
`define RATC_ERR_W 9
`define RATC_CRS_LO 9
`define RATC_CRS_W 7
`define RATC_FINE_W 12

// Stage weights in tenths of an arc second
`define RATC_LSB_GIM_DAS 200
`define RATC_LSB_TRUN_DAS 25

// Stepping rates
`define RATC_CLK_HZ 250000000
`define RATC_FAST_PPS 12800
`define RATC_SLOW_PPS 800
`define RATC_BIG_ERR_AS 400
`define RATC_DIV_W 19

// Reset values
`define RATC_ANG_RST 16'h0000
`define RATC_ERR_RST 9'h000
`define RATC_DIV_RST 19'h00000

`endif

// ---- rtl/ratc_pkg.sv ----
// Purpose: types of the resolver angle tracking counter
// Assumes: ratc_regs.svh holds the numbers
// Notes: mode codes are Gray along null, slow, fast
`include "ratc_regs.svh"
package ratc_pkg;
  typedef logic [`RATC_NCH-1:0] ratc_ch_t;
  typedef logic [`RATC_NCH*`RATC_ANG_W-1:0] ratc_ang_bus_t;
  typedef logic [`RATC_NCH*`RATC_ERR_W-1:0] ratc_err_bus_t;
  typedef logic [`RATC_NGIM*`RATC_CRS_W-1:0] ratc_crs_bus_t;
  typedef logic [`RATC_NCH*`RATC_FINE_W-1:0] ratc_fine_bus_t;
  typedef logic [`RATC_DIV_W-1:0] ratc_div_t;
  typedef enum logic [1:0] {
    RATC_NULL = 2'b00,
    RATC_SLOW = 2'b01,
    RATC_FAST = 2'b11
  } ratc_mode_e;
endpackage

// ---- rtl/ratc_top.sv ----
// Purpose: digital core of a five channel angle coupling unit
// Assumes: error detector levels are synchronous to I_CLK
// Notes: analog switching and D/A paths lie outside
`timescale 1ns/100ps
`include "ratc_regs.svh"
module ratc_top #(
  parameter int unsigned FAST_DIV = `RATC_CLK_HZ / `RATC_FAST_PPS,
  parameter int unsigned SLOW_DIV = `RATC_CLK_HZ / `RATC_SLOW_PPS
) (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Error detector, coarse path (gimbal channels only)
  input wire ratc_pkg::ratc_ch_t I_CRS_ERR,
  input wire ratc_pkg::ratc_ch_t I_CRS_UP,
  // Error detector, fine path
  input wire ratc_pkg::ratc_ch_t I_FINE_ERR,
  input wire ratc_pkg::ratc_ch_t I_FINE_UP,
  // Mismatch above the rate threshold
  input wire ratc_pkg::ratc_ch_t I_ERR_BIG,
  // Pulses from the guidance computer
  input wire ratc_pkg::ratc_ch_t I_CMD_UP,
  input wire ratc_pkg::ratc_ch_t I_CMD_DN,
  // Angle change pulses to the guidance computer
  output logic [`RATC_NCH-1:0] O_PLS_UP,
  output logic [`RATC_NCH-1:0] O_PLS_DN,
  // Counter contents and switch controls
  output ratc_pkg::ratc_ang_bus_t O_ANGLE,
  output ratc_pkg::ratc_err_bus_t O_ERR_CNT,
  output ratc_pkg::ratc_crs_bus_t O_CRS_SW,
  output ratc_pkg::ratc_fine_bus_t O_FINE_SW,
  // Stepping mode per channel
  output logic [`RATC_NCH-1:0] O_FAST
);
  import ratc_pkg::*;

  // Shared rate dividers
  ratc_div_t fast_cnt_q;
  ratc_div_t fast_cnt_d;
  ratc_div_t slow_cnt_q;
  ratc_div_t slow_cnt_d;
  logic fast_tick;
  logic slow_tick;

  // One divider per rate; slow rate exact, fast divide of 19531.25 truncated to 19531
  always_comb begin
    fast_tick = (fast_cnt_q == `RATC_DIV_W'(FAST_DIV - 1));
    slow_tick = (slow_cnt_q == `RATC_DIV_W'(SLOW_DIV - 1));
    fast_cnt_d = fast_tick ? `RATC_DIV_RST : fast_cnt_q + 1'b1;
    slow_cnt_d = slow_tick ? `RATC_DIV_RST : slow_cnt_q + 1'b1;
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      fast_cnt_q <= `RATC_DIV_RST;
      slow_cnt_q <= `RATC_DIV_RST;
    end else if (I_CE) begin
      fast_cnt_q <= fast_cnt_d;
      slow_cnt_q <= slow_cnt_d;
    end
  end

  // Per channel tracking logic
  for (genvar c = 0; c < `RATC_NCH; c++) begin : g_ch
    logic [`RATC_ANG_W-1:0] ang_q;
    logic [`RATC_ANG_W-1:0] ang_d;
    logic [`RATC_ERR_W-1:0] err_q;
    logic [`RATC_ERR_W-1:0] err_d;
    ratc_mode_e mode_q;
    ratc_mode_e mode_d;
    logic up_q;
    logic up_d;
    logic dn_q;
    logic dn_d;
    logic use_crs;
    logic act;
    logic dir_up;
    logic step;
    logic step_up;
    logic step_dn;

    always_comb begin
      // Coarse path wins; optics have no coarse stage
      use_crs = (c < `RATC_NGIM) && I_CRS_ERR[c];
      act = use_crs || I_FINE_ERR[c];
      dir_up = use_crs ? I_CRS_UP[c] : I_FINE_UP[c];
      // Same threshold and rates on every channel
      if (!act) begin
        mode_d = RATC_NULL;
      end else if (I_ERR_BIG[c]) begin
        mode_d = RATC_FAST;
      end else begin
        mode_d = RATC_SLOW;
      end
      // Gate with act so no step lands after null
      case (mode_q)
        RATC_FAST: step = act && fast_tick;
        RATC_SLOW: step = act && slow_tick;
        default: step = 1'b0;
      endcase
      step_up = step && dir_up;
      step_dn = step && !dir_up;
      if (step_up) begin
        ang_d = ang_q + 1'b1;
      end else if (step_dn) begin
        ang_d = ang_q - 1'b1;
      end else begin
        ang_d = ang_q;
      end
      // Carry and borrow of stage 0: two LSBs per pulse
      up_d = step_up && ang_q[0];
      dn_d = step_dn && !ang_q[0];
      // Computer pulses in, read counter steps fed back
      err_d = err_q + `RATC_ERR_W'(I_CMD_UP[c])
            - `RATC_ERR_W'(I_CMD_DN[c])
            + `RATC_ERR_W'(step_dn)
            - `RATC_ERR_W'(step_up);
    end

    always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
        ang_q <= `RATC_ANG_RST;
        err_q <= `RATC_ERR_RST;
        mode_q <= RATC_NULL;
        up_q <= 1'b0;
        dn_q <= 1'b0;
      end else if (I_CE) begin
        ang_q <= ang_d;
        err_q <= err_d;
        mode_q <= mode_d;
        up_q <= up_d;
        dn_q <= dn_d;
      end
    end

    assign O_ANGLE[c*`RATC_ANG_W +: `RATC_ANG_W] = ang_q;
    assign O_ERR_CNT[c*`RATC_ERR_W +: `RATC_ERR_W] = err_q;
    assign O_FINE_SW[c*`RATC_FINE_W +: `RATC_FINE_W] = ang_q[`RATC_FINE_W-1:0];
    assign O_PLS_UP[c] = up_q;
    assign O_PLS_DN[c] = dn_q;
    assign O_FAST[c] = (mode_q == RATC_FAST);

    if (c < `RATC_NGIM) begin : g_crs
      // Top seven stages go straight to the switches
      assign O_CRS_SW[c*`RATC_CRS_W +: `RATC_CRS_W] = ang_q[`RATC_ANG_W-1:`RATC_CRS_LO];
    end
  end

endmodule // ratc_top

// ---- tb/ratc_props.sv ----
// Purpose: assertions on channel 0
// Assumes: synchronous reset
// Notes: channels share one logic
`timescale 1ns/100ps
module ratc_chk import ratc_pkg::*; (
  // Inputs
  input wire logic I_CLK, I_RST_N, I_CE,
  input wire ratc_ch_t I_CRS_ERR, I_FINE_ERR, I_ERR_BIG, I_CMD_UP, I_CMD_DN,
  // Outputs
  input wire logic [4:0] O_PLS_UP, O_PLS_DN, O_FAST,
  input wire ratc_ang_bus_t O_ANGLE,
  input wire ratc_err_bus_t O_ERR_CNT
);
  logic run_q;
  wire [15:0] ang = O_ANGLE[15:0];
  wire [8:0] err = O_ERR_CNT[8:0];
  always_ff @(posedge I_CLK) run_q <= I_RST_N && I_CE;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_up; run_q && ang == $past(ang) + 16'h1; endsequence
  sequence s_dn; run_q && ang == $past(ang) - 16'h1; endsequence
  property p_one; $past(I_RST_N) && $changed(ang) |-> s_up or s_dn; endproperty
  a_one: assert property (p_one) else $error("angle jump");
  property p_up; O_PLS_UP[0] |-> s_up ##0 $past(ang[0]); endproperty
  a_up: assert property (p_up) else $error("bad up pulse");
  property p_dn; O_PLS_DN[0] |-> s_dn ##0 !$past(ang[0]); endproperty
  a_dn: assert property (p_dn) else $error("bad down pulse");
  property p_fb; s_up ##0 !$past(I_CMD_UP[0] | I_CMD_DN[0]) |-> err == $past(err) - 9'h1;
  endproperty
  a_fb: assert property (p_fb) else $error("no feedback");
  property p_cmd; run_q && $stable(ang) && $past(I_CMD_UP[0] & ~I_CMD_DN[0])
    |-> err == $past(err) + 9'h1; endproperty
  a_cmd: assert property (p_cmd) else $error("count lost");
  property p_ce; $past(I_RST_N & ~I_CE) |-> $stable(ang) && $stable(err); endproperty
  a_ce: assert property (p_ce) else $error("not frozen");
  property p_fast; $past(I_RST_N & I_CE & I_FINE_ERR[0] & I_ERR_BIG[0]) |-> O_FAST[0];
  endproperty
  a_fast: assert property (p_fast) else $error("not fast");
  property p_null; $past(I_RST_N & ~I_CRS_ERR[0] & ~I_FINE_ERR[0]) |-> $stable(ang);
  endproperty
  a_null: assert property (p_null) else $error("step at null");
endmodule // ratc_chk
bind ratc_top ratc_chk u_chk (.*);

// ---- tb/ratc_gc.sv ----
// Purpose: guidance computer model
// Assumes: one pulse per high cycle
// Notes: counts channel 0 net pulses
`timescale 1ns/100ps
module ratc_gc import ratc_pkg::*; (
  input wire logic clk,
  input wire ratc_ch_t pls_up, pls_dn, req_up, req_dn,
  output ratc_ch_t cmd_up = 0, cmd_dn = 0,
  output int net0 = 0
);
  always @(posedge clk) begin
    net0 <= net0 + pls_up[0] - pls_dn[0];
    cmd_up <= #1 req_up;
    cmd_dn <= #1 req_dn;
  end
endmodule // ratc_gc

// ---- tb/resolver_angle_tracking_counter_bench.sv ----
// Purpose: bench of ratc_top
// Assumes: dividers cut to 4 and 16
// Notes: fixed seed
`timescale 1ns/100ps
module resolver_angle_tracking_counter_bench;
  import ratc_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1;
  ratc_ch_t c_err = 0, c_up = 0, f_err = 0, f_up = 0, big = 0, r_up = 0, r_dn = 0, cu, cd;
  logic [4:0] pu, pd, fst;
  ratc_ang_bus_t ang;
  ratc_err_bus_t err;
  ratc_crs_bus_t csw;
  ratc_fine_bus_t fsw;
  int failures = 0, n_checks = 0, seed = 27523, cyc = 0, net0, a0, a3;
  int cmd[5] = '{default: 0};
  initial forever #2 clk = ~clk;
  ratc_top #(.FAST_DIV(4), .SLOW_DIV(16)) u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_CRS_ERR(c_err), .I_CRS_UP(c_up), .I_FINE_ERR(f_err), .I_FINE_UP(f_up),
    .I_ERR_BIG(big), .I_CMD_UP(cu), .I_CMD_DN(cd), .O_PLS_UP(pu), .O_PLS_DN(pd),
    .O_ANGLE(ang), .O_ERR_CNT(err), .O_CRS_SW(csw), .O_FINE_SW(fsw), .O_FAST(fst));
  ratc_gc u_gc (.clk(clk), .pls_up(pu), .pls_dn(pd), .req_up(r_up), .req_dn(r_dn),
    .cmd_up(cu), .cmd_dn(cd), .net0(net0));
  task chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] a(int c);
    return ang[16*c +: 16];
  endfunction
  task inv;
    for (int c = 0; c < 5; c++) begin
      chk("err", err[9*c +: 9], 9'(cmd[c] - a(c)));
      chk("fine", fsw[12*c +: 12], a(c) & 16'hfff);
      if (c < 3) chk("crs", csw[7*c +: 7], a(c) >> 9);
    end
  endtask
  // Commands count only on enabled edges, as in the design
  always @(posedge clk) begin
    cyc++;
    if (rst_n && ce) for (int c = 0; c < 5; c++) cmd[c] += cu[c] - cd[c];
    if (cyc == 5000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    go(4);
    rst_n = 1;
    chk("rst", a(2), 0);
    {f_err, f_up, big} = '1;
    go(41);
    chk("fast", fst, 5'h1f);
    for (int c = 0; c < 5; c++) chk("nfast", a(c), 10);
    big = 0;
    a0 = a(0);
    go(160);
    chk("nslow", a(0) - a0, 10);
    {c_err, c_up, f_err, f_up, big} = {5'h09, 5'h01, 5'h01, 5'h00, 5'h1f};
    a0 = a(0);
    a3 = a(3);
    go(40);
    chk("prio", a(0) - a0, 10);
    chk("optic", a(3) - a3, 0);
    repeat (300) begin
      {c_err, c_up, f_err, f_up, big, r_up, r_dn} = {$random(seed), $random(seed)};
      go(8);
      inv;
    end
    {c_err, f_err, r_up, r_dn} = 0;
    go(3);
    ce = 0;
    r_up = '1;
    go(8);
    {r_up, ce} = 6'h01;
    go(3);
    inv;
    chk("pls", 16'(net0 & 'h7fff), a(0) >> 1);
    final_report;
  end
endmodule // resolver_angle_tracking_counter_bench
